// [hdl/quality_monitor_pkg.sv]
/*
  shared constants for the reference input quality monitor register bank:
  register offsets, reset values, field positions and timing counts.
  assumes a 200 MHz system clock and an 8-bit register port.
*/
package quality_monitor_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_FREQ_ALARM_LIMITS  = 8'h49;
  localparam logic [7:0] ADDR_SEL_ALARM_LIMITS   = 8'h4a;  // sits between the two printed ones
  localparam logic [7:0] ADDR_STATUS_VIEW        = 8'h4b;
  localparam logic [7:0] ADDR_MEASURED_OFFSET    = 8'h4c;
  localparam logic [7:0] ADDR_LOOP_SOFT_RANGE    = 8'h4d;
  localparam logic [7:0] ADDR_BUCKET0_RAISE      = 8'h50;
  localparam logic [7:0] ADDR_BUCKET0_CLEAR      = 8'h51;
  localparam logic [7:0] ADDR_BUCKET0_MAX        = 8'h52;
  localparam logic [7:0] ADDR_BUCKET0_DRAIN      = 8'h53;
  localparam logic [7:0] ADDR_BUCKET1_RAISE      = 8'h54;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_FREQ_ALARM_LIMITS   = 8'h23;
  localparam logic [7:0] RST_SEL_ALARM_LIMITS    = 8'h23;
  localparam logic [7:0] RST_STATUS_VIEW         = 8'h00;
  localparam logic [7:0] RST_LOOP_SOFT_RANGE     = 8'h8e;
  localparam logic [7:0] RST_BUCKET0_RAISE       = 8'h06;
  localparam logic [7:0] RST_BUCKET0_CLEAR       = 8'h04;
  localparam logic [7:0] RST_BUCKET0_MAX         = 8'h08;
  localparam logic [7:0] RST_BUCKET0_DRAIN       = 8'h01;
  localparam logic [7:0] RST_BUCKET1_RAISE       = 8'h06;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SOFT_FIELD_LSB      = 4;  // soft limit field [7:4]
  localparam int HARD_FIELD_LSB      = 0;  // hard limit field [3:0]
  localparam int PATH_VIEW_BIT       = 4;  // path_view_select
  localparam int CHANNEL_FIELD_LSB   = 0;  // channel select [3:0]
  localparam int PHASE_DROP_BIT      = 7;  // limit_forces_phase_drop
  localparam logic [3:0] CHANNEL_NONE = 4'hf;

  // ************************************************************
  // timing
  // ************************************************************
  localparam longint CLK_HZ          = 200000000;
  localparam longint EVAL_PERIOD_MS  = 128;
  localparam longint EVAL_CYCLES     = (EVAL_PERIOD_MS * CLK_HZ) / 1000;

endpackage : quality_monitor_pkg

// [hdl/activity_bucket.sv]
/*
  one leaky-bucket activity accumulator for a single input.
  assumes eval_tick is a one-cycle pulse once per evaluation period and
  fault_seen is a level held over the period just ended.
*/
`timescale 1ns/1ps
module activity_bucket (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // period events
  input  wire logic       eval_tick,
  input  wire logic       fault_seen,
  // configuration
  input  wire logic [7:0] raise_level,
  input  wire logic [7:0] clear_level,
  input  wire logic [7:0] max_fill,
  input  wire logic [1:0] drain_rate,
  // state
  output logic      [7:0] fill,
  output logic            alarm
);
  import quality_monitor_pkg::*;

  logic [7:0] fill_q, fill_d;    // accumulator
  logic [2:0] quiet_q, quiet_d;  // fault-free periods seen
  logic       alarm_q, alarm_d;  // activity alarm
  logic [3:0] quiet_need;        // periods per decrement

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    fill_d  = fill_q;
    quiet_d = quiet_q;
    alarm_d = alarm_q;
    quiet_need = 4'h1 << drain_rate;
    if (eval_tick) begin
      if (fault_seen) begin
        quiet_d = 3'h0;
        if (fill_q < max_fill) begin
          fill_d = fill_q + 8'h01;
        end
      end else if ({1'b0, quiet_q} + 4'h1 >= quiet_need) begin
        quiet_d = 3'h0;
        if (fill_q != 8'h00) begin
          fill_d = fill_q - 8'h01;
        end
      end else begin
        quiet_d = quiet_q + 3'h1;
      end
    end
    if (fill_d >= raise_level) begin
      alarm_d = 1'b1;
    end else if (fill_d <= clear_level) begin
      alarm_d = 1'b0;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fill_q  <= 8'h00;
      quiet_q <= 3'h0;
      alarm_q <= 1'b0;
    end else begin
      fill_q  <= fill_d;
      quiet_q <= quiet_d;
      alarm_q <= alarm_d;
    end
  end

  assign fill  = fill_q;
  assign alarm = alarm_q;

  property p_fill_up;
    @(posedge clk_sys) disable iff (rst)
      (eval_tick && fault_seen && fill_q < max_fill) |=> (fill_q == $past(fill_q) + 8'h01);
  endproperty
  a_fill_up: assert property (p_fill_up) else $error("bucket did not fill by one");

  property p_fill_cap;
    @(posedge clk_sys) disable iff (rst)
      (fill_q >= max_fill && eval_tick) |=> (fill_q <= $past(fill_q));
  endproperty
  a_fill_cap: assert property (p_fill_cap) else $error("bucket passed maximum fill");

  property p_alarm_raise;
    @(posedge clk_sys) disable iff (rst)
      (fill_q >= raise_level) |-> alarm_q;
  endproperty
  a_alarm_raise: assert property (p_alarm_raise) else $error("alarm missing at raise level");

  property p_drain_fast;
    @(posedge clk_sys) disable iff (rst)
      (eval_tick && !fault_seen && drain_rate == 2'b00 && fill_q != 8'h00)
        |=> (fill_q == $past(fill_q) - 8'h01);
  endproperty
  a_drain_fast: assert property (p_drain_fast) else $error("no drain on quiet period");

endmodule : activity_bucket

// [hdl/ref_input_quality_monitor_cfg.sv]
/*
  register bank and live logic for reference input quality monitoring:
  frequency alarm limits, status view select, measured offset readback,
  loop soft range and leaky bucket configuration 0 for fourteen inputs.
  assumes a plain 8-bit register port on clk_sys and fault, offset and
  loop indications arriving from other clock domains.
*/
`timescale 1ns/1ps
// Behaviour
// - evaluate accumulators every 128 ms
// - faulty period adds one to accumulator
// - quiet run of 1/2/4/8 subtracts one
// - raise activity alarm at upper level
// - soft limit is (field+1) times 3.81 ppm
// - hard limit same scale, symmetric sign
// - selected input uses its own limits
// - path view bit picks secondary path status
// - channel field picks readback input, 1111 none
// - phase-drop bit forces phase lost at limit
// - monitor clock select crystal or loop
module ref_input_quality_monitor_cfg #(
  parameter int  NUM_INPUTS  = 14,
  parameter longint EVAL_CYCLES_P = quality_monitor_pkg::EVAL_CYCLES
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // register port
  input  wire logic                  reg_cs,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  // per-input monitor evidence, asynchronous
  input  wire logic [NUM_INPUTS-1:0] input_fault,
  input  wire logic [NUM_INPUTS*8-1:0] input_offset,
  input  wire logic [3:0]            selected_input,
  // loop state, asynchronous
  input  wire logic [7:0]            loop_offset,
  input  wire logic                  loop_at_hard_limit,
  input  wire logic                  loop_phase_lost_raw,
  input  wire logic                  monitor_clk_select,
  // path status views
  input  wire logic [7:0]            primary_path_status,
  input  wire logic [7:0]            secondary_path_status,
  // outputs
  output logic      [7:0]            path_status_view,
  output logic      [NUM_INPUTS-1:0] soft_freq_alarm,
  output logic      [NUM_INPUTS-1:0] hard_freq_alarm,
  output logic      [NUM_INPUTS-1:0] activity_alarm,
  output logic                       loop_soft_alarm,
  output logic                       loop_phase_lost,
  output logic                       monitor_from_crystal
);
  import quality_monitor_pkg::*;

  // ************************************************************
  // functions
  // ************************************************************
  // absolute value of a signed offset byte, widened so -128 fits
  function automatic logic [8:0] mag8(input logic [7:0] v);
    mag8 = v[7] ? (9'h000 - {1'b1, v}) : {1'b0, v};
  endfunction : mag8

  // limit code to offset steps; a step of the input monitor is the scale
  function automatic logic [8:0] lim_steps(input logic [3:0] f);
    lim_steps = {5'h00, f} + 9'h001;
  endfunction : lim_steps

  // ************************************************************
  // input synchronisers
  // ************************************************************
  localparam int SYNC_W = NUM_INPUTS * 9 + 4 + 8 + 3;
  // offset, select and loop words are taken only when two samples agree, so
  // a word caught mid-change in the other domain never reaches a comparator
  localparam int WORD_W = NUM_INPUTS * 8 + 4 + 8;
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic [WORD_W-1:0] word3_q, word_q;  // last word sample, accepted word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      word3_q <= '0;
      word_q  <= '0;
    end else begin
      sync1_q <= {input_fault, input_offset, selected_input, loop_offset,
                  loop_at_hard_limit, loop_phase_lost_raw, monitor_clk_select};
      sync2_q <= sync1_q;
      word3_q <= sync2_q[WORD_W+2:3];
      if (sync2_q[WORD_W+2:3] == word3_q) begin
        word_q <= word3_q;
      end
    end
  end
  logic [NUM_INPUTS-1:0]   fault_s;
  logic [NUM_INPUTS*8-1:0] offset_s;
  logic [3:0]              sel_s;
  logic [7:0]              loop_off_s;
  logic                    hard_s, lost_s, clksel_s;
  assign fault_s = sync2_q[SYNC_W-1 -: NUM_INPUTS];
  assign {offset_s, sel_s, loop_off_s} = word_q;
  assign {hard_s, lost_s, clksel_s} = sync2_q[2:0];

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [7:0] limits_q, sel_limits_q, view_q, soft_range_q;
  logic [7:0] raise_q, clear_q, max_q, drain_q, raise1_q;
  logic [7:0] meas_q, meas_d;   // captured readback offset
  logic       wr_en;

  assign wr_en = reg_cs && reg_wr;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      limits_q     <= RST_FREQ_ALARM_LIMITS;
      sel_limits_q <= RST_SEL_ALARM_LIMITS;
      view_q       <= RST_STATUS_VIEW;
      soft_range_q <= RST_LOOP_SOFT_RANGE;
      raise_q      <= RST_BUCKET0_RAISE;
      clear_q      <= RST_BUCKET0_CLEAR;
      max_q        <= RST_BUCKET0_MAX;
      drain_q      <= RST_BUCKET0_DRAIN;
      raise1_q     <= RST_BUCKET1_RAISE;
    end else if (wr_en) begin
      unique case (reg_addr)
        ADDR_FREQ_ALARM_LIMITS: limits_q     <= reg_wdata;
        ADDR_SEL_ALARM_LIMITS:  sel_limits_q <= reg_wdata;
        ADDR_STATUS_VIEW:       view_q       <= {3'h0, reg_wdata[4:0]};
        ADDR_LOOP_SOFT_RANGE:   soft_range_q <= reg_wdata;
        ADDR_BUCKET0_RAISE:     raise_q      <= reg_wdata;
        ADDR_BUCKET0_CLEAR:     clear_q      <= reg_wdata;
        ADDR_BUCKET0_MAX:       max_q        <= reg_wdata;
        ADDR_BUCKET0_DRAIN:     drain_q      <= {6'h00, reg_wdata[1:0]};
        ADDR_BUCKET1_RAISE:     raise1_q     <= reg_wdata;
        default: ;              // read-only or unmapped: ignored
      endcase
    end
  end

  // read mux, registered data out
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        ADDR_FREQ_ALARM_LIMITS: reg_rdata <= limits_q;
        ADDR_SEL_ALARM_LIMITS:  reg_rdata <= sel_limits_q;
        ADDR_STATUS_VIEW:       reg_rdata <= view_q;
        ADDR_MEASURED_OFFSET:   reg_rdata <= meas_q;
        ADDR_LOOP_SOFT_RANGE:   reg_rdata <= soft_range_q;
        ADDR_BUCKET0_RAISE:     reg_rdata <= raise_q;
        ADDR_BUCKET0_CLEAR:     reg_rdata <= clear_q;
        ADDR_BUCKET0_MAX:       reg_rdata <= max_q;
        ADDR_BUCKET0_DRAIN:     reg_rdata <= drain_q;
        ADDR_BUCKET1_RAISE:     reg_rdata <= raise1_q;
        default:                reg_rdata <= 8'h00;  // unmapped reads zero
      endcase
    end
  end

  // ************************************************************
  // readback and path view
  // ************************************************************
  always_comb begin
    meas_d = meas_q;
    if (view_q[3:0] == CHANNEL_NONE || view_q[3:0] == 4'h0) begin
      meas_d = 8'h00;
    end else if (32'(view_q[3:0]) <= NUM_INPUTS) begin
      meas_d = offset_s[(32'(view_q[3:0]) - 1) * 8 +: 8];
    end
  end

  logic [7:0] view_out_d;
  always_comb begin
    view_out_d = view_q[PATH_VIEW_BIT] ? secondary_path_status : primary_path_status;
  end

  // ************************************************************
  // evaluation period timer
  // ************************************************************
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic        eval_tick;
  always_comb begin
    eval_tick  = (tick_cnt_q == 32'(EVAL_CYCLES_P - 1));
    tick_cnt_d = eval_tick ? 32'h0 : tick_cnt_q + 32'h1;
  end

  // fault latched over the period, set wins over period clear
  logic [NUM_INPUTS-1:0] seen_q, seen_d;
  always_comb begin
    seen_d = eval_tick ? fault_s : (seen_q | fault_s);
  end

  // ************************************************************
  // frequency alarms and loop
  // ************************************************************
  logic [NUM_INPUTS-1:0] soft_d, hard_d;
  logic                  loop_soft_d, lost_d;
  logic [7:0]            lim;  // limits in force for one input
  always_comb begin
    lim = limits_q;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      lim = (sel_s == 4'(i + 1)) ? sel_limits_q : limits_q;
      soft_d[i] = mag8(offset_s[i*8 +: 8]) > lim_steps(lim[SOFT_FIELD_LSB +: 4]);
      hard_d[i] = mag8(offset_s[i*8 +: 8]) > lim_steps(lim[HARD_FIELD_LSB +: 4]);
    end
    loop_soft_d = mag8(loop_off_s) > {2'h0, soft_range_q[6:0]};
    lost_d = lost_s || (soft_range_q[PHASE_DROP_BIT] && hard_s);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meas_q               <= 8'h00;
      path_status_view     <= 8'h00;
      tick_cnt_q           <= 32'h0;
      seen_q               <= '0;
      soft_freq_alarm      <= '0;
      hard_freq_alarm      <= '0;
      loop_soft_alarm      <= 1'b0;
      loop_phase_lost      <= 1'b0;
      monitor_from_crystal <= 1'b0;
    end else begin
      meas_q               <= meas_d;
      path_status_view     <= view_out_d;
      tick_cnt_q           <= tick_cnt_d;
      seen_q               <= seen_d;
      soft_freq_alarm      <= soft_d;
      hard_freq_alarm      <= hard_d;
      loop_soft_alarm      <= loop_soft_d;
      loop_phase_lost      <= lost_d;
      monitor_from_crystal <= clksel_s;
    end
  end

  // ************************************************************
  // leaky buckets, one per input
  // ************************************************************
  generate
    for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_bucket
      activity_bucket u_bucket (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .eval_tick   (eval_tick),
        .fault_seen  (seen_q[g] | fault_s[g]),
        .raise_level (raise_q),
        .clear_level (clear_q),
        .max_fill    (max_q),
        .drain_rate  (drain_q[1:0]),
        .fill        (),
        .alarm       (activity_alarm[g])
      );
    end
  endgenerate

  // ************************************************************
  // checks
  // ************************************************************
  property p_tick_period;
    @(posedge clk_sys) disable iff (rst)
      eval_tick |=> !eval_tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("evaluation ticks back to back");

  property p_phase_drop;
    @(posedge clk_sys) disable iff (rst)
      (soft_range_q[PHASE_DROP_BIT] && hard_s) |=> loop_phase_lost;
  endproperty
  a_phase_drop: assert property (p_phase_drop) else $error("phase lost not forced");

  property p_view;
    @(posedge clk_sys) disable iff (rst)
      view_q[PATH_VIEW_BIT] |=> (path_status_view == $past(secondary_path_status));
  endproperty
  a_view: assert property (p_view) else $error("secondary view not shown");

  property p_no_channel;
    @(posedge clk_sys) disable iff (rst)
      (view_q[3:0] == CHANNEL_NONE) |=> (meas_q == 8'h00);
  endproperty
  a_no_channel: assert property (p_no_channel) else $error("readback not zero for no input");

endmodule : ref_input_quality_monitor_cfg

// [verif/ref_input_quality_monitor_cfg_tb_top.sv]
/*
  self-checking bench for the quality monitor register bank: register
  port, frequency alarms, readback, loop limits and leaky bucket 0.
  assumes quality_monitor_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module ref_input_quality_monitor_cfg_tb_top;
  import quality_monitor_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  localparam int EV = 100;                         // short period for sim
  logic         clk_sys               = 1'b0;
  logic         rst                   = 1'b1;
  logic         reg_cs                = 1'b0;
  logic         reg_wr                = 1'b0;
  logic [7:0]   reg_addr              = 8'h00;
  logic [7:0]   reg_wdata             = 8'h00;
  logic [7:0]   reg_rdata;
  logic [13:0]  input_fault           = 14'h0000;
  logic [111:0] input_offset          = 112'h0;
  logic [3:0]   selected_input        = 4'h0;
  logic [7:0]   loop_offset           = 8'h00;
  logic         loop_at_hard_limit    = 1'b0;
  logic         loop_phase_lost_raw   = 1'b0;
  logic         monitor_clk_select    = 1'b0;
  logic [7:0]   primary_path_status   = 8'h00;
  logic [7:0]   secondary_path_status = 8'h00;
  logic [7:0]   path_status_view;
  logic [13:0]  soft_freq_alarm;
  logic [13:0]  hard_freq_alarm;
  logic [13:0]  activity_alarm;
  logic         loop_soft_alarm;
  logic         loop_phase_lost;
  logic         monitor_from_crystal;
  int           errors                = 0;       // mismatches
  int           n_compared            = 0;       // comparisons made
  // register table: offsets, reset values, writable bits
  logic [7:0]   ra [9] = '{8'h49, 8'h4a, 8'h4b, 8'h4d, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54};
  logic [7:0]   rr [9] = '{8'h23, 8'h23, 8'h00, 8'h8e, 8'h06, 8'h04, 8'h08, 8'h01, 8'h06};
  logic [7:0]   rm [9] = '{8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff};

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  ref_input_quality_monitor_cfg #(.NUM_INPUTS(14), .EVAL_CYCLES_P(EV)) ref_input_quality_monitor_cfg_i (
    .clk_sys(clk_sys), .rst(rst), .reg_cs(reg_cs), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .input_fault(input_fault), .input_offset(input_offset),
    .selected_input(selected_input), .loop_offset(loop_offset),
    .loop_at_hard_limit(loop_at_hard_limit), .loop_phase_lost_raw(loop_phase_lost_raw),
    .monitor_clk_select(monitor_clk_select), .primary_path_status(primary_path_status),
    .secondary_path_status(secondary_path_status), .path_status_view(path_status_view),
    .soft_freq_alarm(soft_freq_alarm), .hard_freq_alarm(hard_freq_alarm),
    .activity_alarm(activity_alarm), .loop_soft_alarm(loop_soft_alarm),
    .loop_phase_lost(loop_phase_lost), .monitor_from_crystal(monitor_from_crystal));

  // ************************************************************
  // shared tasks
  // ************************************************************
  // one write cycle; strobes drop at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_cs    <= 1'b1;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_cs <= 1'b0;
    reg_wr <= 1'b0;
  endtask : wr

  // read one register, data lands one edge after the address
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    @(posedge clk_sys);
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : chk_reg

  // async words need two sync flops, the agreement flops and the output flop
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // ************************************************************
  // scenarios
  // ************************************************************
  // reset values, writable bits, read-only and unmapped places
  task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
      chk_reg(ra[i], rr[i]);
      wr(ra[i], 8'hff);
      chk_reg(ra[i], rm[i]);
      wr(ra[i], rr[i]);
    end
    wr(8'h4c, 8'h5a);
    chk_reg(8'h4c, 8'h00);
    wr(8'h4e, 8'hff);
    chk_reg(8'h4e, 8'h00);
    $display("done regs");
  endtask : t_regs

  // shared limits 3/4 units, selected input limits 1/1
  task automatic t_freq();
    wr(8'h49, 8'h23);
    wr(8'h4a, 8'h00);
    @(posedge clk_sys);
    input_offset   <= {72'h0, 8'hfd, 8'h02, 8'h02, 8'hfb, 8'h04};
    selected_input <= 4'h3;
    settle();
    `CHK("soft_freq_alarm", 14'h0007, soft_freq_alarm)
    `CHK("hard_freq_alarm", 14'h0006, hard_freq_alarm)
    @(posedge clk_sys);
    selected_input <= 4'h4;
    settle();
    `CHK("soft_freq_alarm", 14'h000b, soft_freq_alarm)
    `CHK("hard_freq_alarm", 14'h000a, hard_freq_alarm)
    $display("done freq");
  endtask : t_freq

  // path view bit and every readback channel code
  task automatic t_view();
    logic [7:0] exp;
    @(posedge clk_sys);
    primary_path_status   <= 8'ha5;
    secondary_path_status <= 8'h5a;
    for (int i = 0; i < 14; i++) begin
      input_offset[i*8 +: 8] <= 8'h30 + 8'(i);
    end
    wr(8'h4b, 8'h00);
    settle();
    `CHK("path_status_view", 8'ha5, path_status_view)
    wr(8'h4b, 8'h10);
    settle();
    `CHK("path_status_view", 8'h5a, path_status_view)
    for (int c = 0; c < 16; c++) begin
      wr(8'h4b, 8'(c));
      exp = (c == 0 || c == 15) ? 8'h00 : 8'h2f + 8'(c);
      chk_reg(8'h4c, exp);
    end
    $display("done view");
  endtask : t_view

  // loop soft range of 5 steps, both signs, and phase-drop override
  task automatic t_loop();
    logic [7:0] offs [4] = '{8'h06, 8'h05, 8'hfa, 8'hfb};
    logic       alrm [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(8'h4d, 8'h85);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      loop_offset <= offs[i];
      settle();
      `CHK("loop_soft_alarm", alrm[i], loop_soft_alarm)
    end
    `CHK("loop_phase_lost", 1'b0, loop_phase_lost)
    @(posedge clk_sys);
    loop_at_hard_limit <= 1'b1;
    settle();
    `CHK("loop_phase_lost", 1'b1, loop_phase_lost)
    wr(8'h4d, 8'h05);
    settle();
    `CHK("loop_phase_lost", 1'b0, loop_phase_lost)
    @(posedge clk_sys);
    loop_phase_lost_raw <= 1'b1;
    settle();
    `CHK("loop_phase_lost", 1'b1, loop_phase_lost)
    @(posedge clk_sys);
    loop_phase_lost_raw <= 1'b0;
    loop_at_hard_limit  <= 1'b0;
    monitor_clk_select  <= 1'b1;
    settle();
    `CHK("monitor_from_crystal", 1'b1, monitor_from_crystal)
    @(posedge clk_sys);
    monitor_clk_select <= 1'b0;
    settle();
    `CHK("monitor_from_crystal", 1'b0, monitor_from_crystal)
    $display("done loop");
  endtask : t_loop

  // raise 3, clear 1, max 4; windows allow for the unknown tick phase
  task automatic t_bucket(input int c);
    int n;
    n = 3 << c;
    wr(8'h53, 8'(c));
    @(posedge clk_sys);
    input_fault <= 14'h0001;
    if (c == 0) begin
      repeat (190) @(posedge clk_sys);
      #1;
      `CHK("activity_alarm", 14'h0000, activity_alarm)
      repeat (220) @(posedge clk_sys);
      #1;
      `CHK("activity_alarm", 14'h0001, activity_alarm)
    end
    // many faulty periods; the fill must stop at max
    repeat (800) @(posedge clk_sys);
    input_fault <= 14'h0000;
    repeat ((n - (1 << c)) * EV - 10) @(posedge clk_sys);
    #1;
    `CHK("activity_alarm", 14'h0001, activity_alarm)
    repeat (((1 << c) + 2) * EV + 10) @(posedge clk_sys);
    #1;
    `CHK("activity_alarm", 14'h0000, activity_alarm)
    $display("done bucket drain %0d", c);
  endtask : t_bucket

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_freq();
    t_view();
    t_loop();
    wr(8'h50, 8'h03);
    wr(8'h51, 8'h01);
    wr(8'h52, 8'h04);
    for (int c = 0; c < 4; c++) begin
      t_bucket(c);
    end
    give_verdict();
  end

  // the run needs about 10000 cycles; twice that means a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end

endmodule : ref_input_quality_monitor_cfg_tb_top
